/* mdam_pkg.sv */
// Purpose: shared constants for the motor driver alarm manager
// Assumes: 100 MHz pclk, APB register access with 32-bit data
// Notes: alarm codes are the two display digits, held as hex
package mdam_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_DEV_THR = 8'h08;
  localparam logic [7:0] ADDR_TLIM = 8'h0C;
  localparam logic [7:0] ADDR_DISP = 8'h10;
  localparam logic [7:0] ADDR_HCNT = 8'h14;
  localparam logic [7:0] ADDR_HIST0 = 8'h20;
  localparam logic [7:0] ADDR_HLAST = 8'h44;
  // Field positions
  localparam int CTRL_ALM_CLR = 0;
  localparam int CTRL_HIST_CLR = 1;
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_OK = 1;
  localparam int STAT_CAUTION = 2;
  localparam int STAT_RSTIND = 3;
  localparam int STAT_CODE_LSB = 8;
  localparam int STAT_LATCH_LSB = 16;
  // Reset values
  localparam logic [15:0] DEV_THR_RST = 16'h0400;
  localparam logic [15:0] TLIM_RST = 16'h012C;
  localparam logic [7:0] DISP_RST = 8'h00;
  // Alarm slots
  localparam int NUM_AL = 10;
  localparam int AI_DEV = 0;
  localparam int AI_OCUR = 1;
  localparam int AI_OVOLT = 2;
  localparam int AI_UVOLT = 3;
  localparam int AI_SENS = 4;
  localparam int AI_MAIN = 5;
  localparam int AI_OVLD = 6;
  localparam int AI_OSPD = 7;
  localparam int AI_NVM = 8;
  localparam int AI_INIT = 9;
  // Slots that the clear input, panel and software may clear
  localparam logic [NUM_AL-1:0] CLEARABLE = 10'h0C9;
  // Thresholds: 120 %, 60 %, 5200 r/min, 250 %
  localparam logic [7:0] OVOLT_PCT = 8'h78;
  localparam logic [7:0] UVOLT_PCT = 8'h3C;
  localparam logic [15:0] SPEED_MAX = 16'h1450;
  localparam logic [15:0] TLIM_SUPP_PCT = 16'h00FA;
  // History
  localparam int HIST_DEPTH = 10;
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int OVLD_TIME_MS = 5000;
  localparam int OVLD_CYC = OVLD_TIME_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b01,
    ST_ALARM = 2'b10
  } mdam_state_t;

  function automatic logic [7:0] mdam_code_of(input logic [3:0] idx);
    logic [7:0] c;
    c = 8'h00;
    unique case (idx)
      4'h0: c = 8'h10;
      4'h1: c = 8'h20;
      4'h2: c = 8'h22;
      4'h3: c = 8'h25;
      4'h4: c = 8'h28;
      4'h5: c = 8'h24;
      4'h6: c = 8'h30;
      4'h7: c = 8'h31;
      4'h8: c = 8'h41;
      4'h9: c = 8'h42;
      default: c = 8'h00;
    endcase
    return c;
  endfunction
endpackage

/* mdam_hist_if.sv */
// Purpose: link between the alarm core and its history store
// Assumes: one push and one read port, all on pclk
// Notes: read is combinational from rd_idx
`timescale 1ns/100ps
`default_nettype none
interface mdam_hist_if;
  logic push;
  logic [7:0] push_code;
  logic clear;
  logic [3:0] rd_idx;
  logic [7:0] rd_code;
  logic [3:0] count;
  modport core (output push, output push_code, output clear, output rd_idx,
    input rd_code, input count);
  modport store (input push, input push_code, input clear, input rd_idx,
    output rd_code, output count);
endinterface
`default_nettype wire

/* mdam_clr_edge.sv */
// Purpose: turn the host alarm-clear input into a clear pulse
// Assumes: inputs synchronous to pclk
// Notes: only the ON-to-OFF edge counts, and only with no run input
`timescale 1ns/100ps
`default_nettype none
module mdam_clr_edge (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host inputs
  input wire logic clr_in,
  input wire logic run_in,
  // Result
  output logic clr_pulse
);
  logic prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= clr_in;
    end
  end

  // Edge seen while a run input is on is dropped, not deferred
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_pulse <= 1'b0;
    end else begin
      clr_pulse <= prev_q & ~clr_in & ~run_in;
    end
  end
endmodule
`default_nettype wire

/* mdam_history.sv */
// Purpose: ten-entry alarm history, newest in entry 0
// Assumes: contents kept by the surrounding non-volatile supply domain
// Notes: a push in the clear cycle survives as the sole entry
`timescale 1ns/100ps
`default_nettype none
module mdam_history
  import mdam_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Core side
  mdam_hist_if.store hif
);
  logic [7:0] ent_q [HIST_DEPTH];
  logic [3:0] count_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        ent_q[i] <= 8'h00;
      end
    end else if (hif.push) begin
      // Shifting drops the oldest entry once full
      for (int i = HIST_DEPTH - 1; i > 0; i--) begin
        ent_q[i] <= ent_q[i-1];
      end
      ent_q[0] <= hif.push_code;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 4'h0;
    end else if (hif.clear) begin
      count_q <= hif.push ? 4'h1 : 4'h0;
    end else if (hif.push && count_q != 4'(HIST_DEPTH)) begin
      count_q <= count_q + 4'h1;
    end
  end

  assign hif.count = count_q;
  assign hif.rd_code = (hif.rd_idx < count_q) ? ent_q[hif.rd_idx] : 8'h00;
endmodule
`default_nettype wire

/* mdam_alarm_mgr.sv */
// Purpose: alarm latch, clear handling, display and history for a motor driver
// Assumes: fault sensing arrives as synchronous flags and values; APB slave
// Notes: every alarm here is of the excitation-off class
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module mdam_alarm_mgr
  import mdam_pkg::*;
#(
  parameter int OVLD_CYCLES = OVLD_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fault sensing
  input wire logic excited,
  input wire logic [15:0] pos_dev,
  input wire logic over_current,
  input wire logic [7:0] supply_pct,
  input wire logic encoder_lost,
  input wire logic motor_line_lost,
  input wire logic over_torque,
  input wire logic [15:0] shaft_speed,
  input wire logic nvm_fault,
  input wire logic warn_cause,
  // Host discrete inputs
  input wire logic fault_clear_input,
  input wire logic forward_run_input,
  input wire logic reverse_run_input,
  // Panel monitor commands
  input wire logic panel_alarm_clear,
  input wire logic panel_hist_clear,
  input wire logic panel_item_step,
  // Discrete outputs
  output logic fault_ok_output,
  output logic caution_output,
  output logic motor_stop,
  output logic excite_off,
  output logic brake_engage,
  // Display
  output logic [7:0] disp_code,
  output logic disp_reset_ind
);
  mdam_hist_if hif ();

  mdam_state_t state_q;
  logic [NUM_AL-1:0] alarm_q;
  logic [NUM_AL-1:0] alarm_d;
  logic [NUM_AL-1:0] det;
  logic [NUM_AL-1:0] kept;
  logic [NUM_AL-1:0] fresh;
  logic [7:0] code_q;
  logic [15:0] dev_thr_q;
  logic [15:0] tlim_q;
  logic [7:0] disp_item_q;
  logic [31:0] ovld_cnt_q;
  logic init_chk_q;
  logic run_any;
  logic in_clr;
  logic any_clr;
  logic rstind_q;
  logic acc;
  logic wr_fire;
  logic addr_hit;
  logic [31:0] rd_word;
  logic [7:0] hoff;
  logic sw_alm_clr;
  logic sw_hist_clr;
  logic disp_wr;

  function automatic logic [3:0] first_set(input logic [NUM_AL-1:0] v);
    logic [3:0] idx;
    logic found;
    idx = 4'h0;
    found = 1'b0;
    for (int i = 0; i < NUM_AL; i++) begin
      if (v[i] && !found) begin
        idx = 4'(i);
        found = 1'b1;
      end
    end
    return idx;
  endfunction

  function automatic logic is_hist(input logic [11:0] a);
    return a[11:8] == 4'h0 && a[7:0] >= ADDR_HIST0 && a[7:0] <= ADDR_HLAST &&
      a[1:0] == 2'b00;
  endfunction

  assign run_any = forward_run_input | reverse_run_input;

  mdam_clr_edge u_clr (
    .pclk(pclk),
    .presetn(presetn),
    .clr_in(fault_clear_input),
    .run_in(run_any),
    .clr_pulse(in_clr)
  );

  mdam_history u_hist (
    .pclk(pclk),
    .presetn(presetn),
    .hif(hif.store)
  );

  // APB: pready rises one cycle into the access phase
  assign acc = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite;
  assign hoff = paddr[7:0] - ADDR_HIST0;
  assign sw_alm_clr = wr_fire && paddr == {4'h0, ADDR_CTRL} && pwdata[CTRL_ALM_CLR];
  assign sw_hist_clr = wr_fire && paddr == {4'h0, ADDR_CTRL} && pwdata[CTRL_HIST_CLR];
  assign disp_wr = wr_fire && paddr == {4'h0, ADDR_DISP};

  always_comb begin
    rd_word = 32'h0000_0000;
    addr_hit = 1'b1;
    if (is_hist(paddr)) begin
      rd_word = {24'h00_0000, hif.rd_code};
    end else if (paddr[11:8] != 4'h0) begin
      addr_hit = 1'b0;
    end else begin
      unique case (paddr[7:0])
        ADDR_CTRL: rd_word = 32'h0000_0000;
        ADDR_STAT: begin
          rd_word[STAT_ACTIVE] = state_q == ST_ALARM;
          rd_word[STAT_OK] = fault_ok_output;
          rd_word[STAT_CAUTION] = caution_output;
          rd_word[STAT_RSTIND] = rstind_q;
          rd_word[STAT_CODE_LSB +: 8] = code_q;
          rd_word[STAT_LATCH_LSB +: NUM_AL] = alarm_q;
        end
        ADDR_DEV_THR: rd_word = {16'h0000, dev_thr_q};
        ADDR_TLIM: rd_word = {16'h0000, tlim_q};
        ADDR_DISP: rd_word = {24'h00_0000, disp_item_q};
        ADDR_HCNT: rd_word = {28'h000_0000, hif.count};
        default: addr_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc & ~addr_hit;
      if (acc && !pwrite) begin
        prdata <= rd_word;
      end
    end
  end

  // Software settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_thr_q <= DEV_THR_RST;
      tlim_q <= TLIM_RST;
      disp_item_q <= DISP_RST;
    end else if (wr_fire) begin
      if (paddr == {4'h0, ADDR_DEV_THR}) begin
        dev_thr_q <= pwdata[15:0];
      end
      if (paddr == {4'h0, ADDR_TLIM}) begin
        tlim_q <= pwdata[15:0];
      end
      if (disp_wr) begin
        disp_item_q <= pwdata[7:0];
      end
    end
  end

  // Power-up encoder check runs only in the first cycle after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_chk_q <= 1'b1;
    end else begin
      init_chk_q <= 1'b0;
    end
  end

  // Overload timer saturates so a long overload keeps asserting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovld_cnt_q <= 32'h0000_0000;
    end else if (!over_torque) begin
      ovld_cnt_q <= 32'h0000_0000;
    end else if (ovld_cnt_q != 32'(OVLD_CYCLES - 1)) begin
      ovld_cnt_q <= ovld_cnt_q + 32'h0000_0001;
    end
  end

  always_comb begin
    det = '0;
    det[AI_DEV] = excited && pos_dev > dev_thr_q;
    det[AI_OCUR] = over_current;
    det[AI_OVOLT] = supply_pct > OVOLT_PCT;
    det[AI_UVOLT] = supply_pct < UVOLT_PCT;
    det[AI_SENS] = encoder_lost && run_any;
    // A low torque limit masks the output-line check
    det[AI_MAIN] = motor_line_lost && tlim_q >= TLIM_SUPP_PCT;
    det[AI_OVLD] = over_torque && ovld_cnt_q == 32'(OVLD_CYCLES - 1);
    det[AI_OSPD] = shaft_speed > SPEED_MAX;
    det[AI_NVM] = nvm_fault;
    det[AI_INIT] = init_chk_q && encoder_lost;
  end

  // Power-on clearing is the asynchronous reset itself
  assign any_clr = in_clr | panel_alarm_clear | sw_alm_clr;

  always_comb begin
    kept = any_clr ? (alarm_q & ~CLEARABLE) : alarm_q;
    fresh = det & ~kept;
    alarm_d = kept | det;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_q <= '0;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_NORMAL;
    end else begin
      unique case (state_q)
        ST_NORMAL: begin
          if (|alarm_d) begin
            state_q <= ST_ALARM;
          end
        end
        ST_ALARM: begin
          if (!(|alarm_d)) begin
            state_q <= ST_NORMAL;
          end
        end
        default: state_q <= ST_NORMAL;
      endcase
    end
  end

  // First alarm names the display; a partial clear shows a survivor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q <= 8'h00;
    end else if (!(|alarm_d)) begin
      code_q <= 8'h00;
    end else if (!(|kept)) begin
      code_q <= mdam_code_of(first_set(fresh));
    end else if (kept != alarm_q) begin
      code_q <= mdam_code_of(first_set(kept));
    end
  end

  assign hif.push = |fresh;
  assign hif.push_code = mdam_code_of(first_set(fresh));
  assign hif.clear = panel_hist_clear | sw_hist_clr;
  assign hif.rd_idx = hoff[5:2];

  // Indication only when the clear input empties the latch; set beats item change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rstind_q <= 1'b0;
    end else if (in_clr && (|alarm_q) && !(|alarm_d)) begin
      rstind_q <= 1'b1;
    end else if (panel_item_step || disp_wr || (|alarm_d)) begin
      rstind_q <= 1'b0;
    end
  end

  // Outputs all update in the cycle the alarm latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_ok_output <= 1'b0;
      motor_stop <= 1'b1;
      excite_off <= 1'b1;
      brake_engage <= 1'b1;
    end else begin
      fault_ok_output <= ~(|alarm_d);
      motor_stop <= |alarm_d;
      excite_off <= |alarm_d;
      brake_engage <= |alarm_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_code <= 8'h00;
      disp_reset_ind <= 1'b0;
    end else begin
      if (!(|alarm_d)) begin
        disp_code <= 8'h00;
      end else if (!(|kept)) begin
        disp_code <= mdam_code_of(first_set(fresh));
      end else if (kept != alarm_q) begin
        disp_code <= mdam_code_of(first_set(kept));
      end
      if (in_clr && (|alarm_q) && !(|alarm_d)) begin
        disp_reset_ind <= 1'b1;
      end else if (panel_item_step || disp_wr || (|alarm_d)) begin
        disp_reset_ind <= 1'b0;
      end
    end
  end

  // Warnings never latch and never stop the motor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      caution_output <= 1'b0;
    end else begin
      caution_output <= warn_cause;
    end
  end
endmodule
`default_nettype wire

/* mdam_placeholder_unused.sv */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* mdam_alarm_mgr_checker.sv */
// Purpose: port-level assertions for the alarm manager
// Assumes: single pclk domain, presetn asynchronous active low
// Notes: bound to every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module mdam_checker
  import mdam_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Fault sensing
  input wire logic over_current,
  input wire logic [7:0] supply_pct,
  input wire logic [15:0] shaft_speed,
  input wire logic warn_cause,
  // Outputs
  input wire logic fault_ok_output,
  input wire logic caution_output,
  input wire logic motor_stop,
  input wire logic excite_off,
  input wire logic brake_engage,
  input wire logic [7:0] disp_code,
  input wire logic disp_reset_ind
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  stop_with_alarm_a: assert property (motor_stop == !fault_ok_output)
    else $error("motor stop disagrees with ok output");
  brake_excite_off_a: assert property (excite_off == motor_stop &&
    brake_engage == motor_stop)
    else $error("brake or excitation disagrees with stop");
  // Ok output leaves its reset level only one edge after release
  code_with_alarm_a: assert property ($past(presetn) |->
    fault_ok_output == (disp_code == 8'h00))
    else $error("display code disagrees with ok output");
  ocur_latches_a: assert property (over_current |=> !fault_ok_output)
    else $error("overcurrent did not raise alarm");
  ovolt_latches_a: assert property (supply_pct > OVOLT_PCT |=> !fault_ok_output)
    else $error("overvoltage did not raise alarm");
  ospd_latches_a: assert property (shaft_speed > SPEED_MAX |=> !fault_ok_output)
    else $error("overspeed did not raise alarm");
  caution_follows_a: assert property (1'b1 |=> caution_output == $past(warn_cause))
    else $error("caution output does not follow cause");
  apb_one_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not after one wait");
  ind_on_clear_a: assert property ($rose(disp_reset_ind) |-> fault_ok_output)
    else $error("reset indication without clear");
  cover property ($rose(disp_reset_ind));
  cover property (supply_pct > OVOLT_PCT);
  cover property (pslverr && pready);
endmodule
bind mdam_alarm_mgr mdam_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .over_current(over_current),
  .supply_pct(supply_pct), .shaft_speed(shaft_speed), .warn_cause(warn_cause),
  .fault_ok_output(fault_ok_output), .caution_output(caution_output),
  .motor_stop(motor_stop), .excite_off(excite_off), .brake_engage(brake_engage),
  .disp_code(disp_code), .disp_reset_ind(disp_reset_ind));
`default_nettype wire

/* mdam_host_model.sv */
// Purpose: host controller driving the run and alarm-clear inputs
// Assumes: inputs change just after a rising pclk edge
// Notes: HOLD_CYC is shortened in the bench to keep the run short
`timescale 1ns/100ps
`default_nettype none
module mdam_host_model #(
  parameter int HOLD_CYC = 1000000
) (
  // Clock
  input wire logic pclk,
  // Discrete outputs to the driver
  output logic fault_clear_input,
  output logic forward_run_input
);
  initial begin
    fault_clear_input = 1'b0;
    forward_run_input = 1'b0;
  end
  task automatic run(input logic v);
    @(posedge pclk);
    forward_run_input <= v;
  endtask
  // Skipping the run drop is only for the refusal scenario
  task automatic pulse(input logic drop_run);
    @(posedge pclk);
    if (drop_run) begin
      forward_run_input <= 1'b0;
      @(posedge pclk);
    end
    fault_clear_input <= 1'b1;
    repeat (HOLD_CYC) @(posedge pclk);
    fault_clear_input <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb_motor_driver_alarm_manager.sv */
// Purpose: self-checking bench for the alarm manager
// Assumes: 100 MHz pclk, host model on clear and run inputs
// Notes: overload count shortened to 20 cycles
`timescale 1ns/100ps
`default_nettype none
module tb_motor_driver_alarm_manager;
  import mdam_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, fault_ok_output, caution_output, motor_stop, excite_off;
  logic brake_engage, disp_reset_ind, fault_clear_input, forward_run_input;
  logic [7:0] disp_code;
  logic excited = 1'b0, over_current = 1'b0, encoder_lost = 1'b0, motor_line_lost = 1'b0;
  logic over_torque = 1'b0, nvm_fault = 1'b0, warn_cause = 1'b0;
  logic panel_alarm_clear = 1'b0, panel_hist_clear = 1'b0, panel_item_step = 1'b0;
  logic reverse_run_input = 1'b0;
  logic [15:0] pos_dev = 16'h0000, shaft_speed = 16'h0000;
  logic [7:0] supply_pct = 8'h64;
  logic [7:0] exp_code [8] = '{8'h10, 8'h20, 8'h22, 8'h25, 8'h28, 8'h24, 8'h31, 8'h41};
  logic [7:0] exp_clr = 8'h49;
  int n_errors = 0, check_count = 0;
  always #5 pclk = ~pclk;
  mdam_alarm_mgr #(.OVLD_CYCLES(20)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .excited(excited), .pos_dev(pos_dev),
    .over_current(over_current), .supply_pct(supply_pct), .encoder_lost(encoder_lost),
    .motor_line_lost(motor_line_lost), .over_torque(over_torque), .shaft_speed(shaft_speed),
    .nvm_fault(nvm_fault), .warn_cause(warn_cause), .fault_clear_input(fault_clear_input),
    .forward_run_input(forward_run_input), .reverse_run_input(reverse_run_input),
    .panel_alarm_clear(panel_alarm_clear), .panel_hist_clear(panel_hist_clear),
    .panel_item_step(panel_item_step), .fault_ok_output(fault_ok_output),
    .caution_output(caution_output), .motor_stop(motor_stop), .excite_off(excite_off),
    .brake_engage(brake_engage), .disp_code(disp_code), .disp_reset_ind(disp_reset_ind));
  mdam_host_model #(.HOLD_CYC(50)) host (.pclk(pclk), .fault_clear_input(fault_clear_input),
    .forward_run_input(forward_run_input));
  task automatic test_done();
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask
  // Ends on a rising edge: outputs read here are those launched one edge earlier
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {4'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(name, e, rd);
  endtask
  task automatic fault(input int i, input logic on);
    case (i)
      0: begin
        excited <= on;
        pos_dev <= on ? 16'h0401 : 16'h0000;
      end
      1: over_current <= on;
      2: supply_pct <= on ? 8'h79 : 8'h64;
      3: supply_pct <= on ? 8'h3B : 8'h64;
      4: encoder_lost <= on;
      5: motor_line_lost <= on;
      6: shaft_speed <= on ? 16'h1451 : 16'h0000;
      default: nvm_fault <= on;
    endcase
  endtask
  task automatic raise(input int i);
    fault(i, 1'b1);
    tick(2);
    fault(i, 1'b0);
    tick(1);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    tick(6);
    presetn <= 1'b1;
    tick(2);
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    test_done();
  end
  initial begin
    do_reset();
    rchk("dev_thr", ADDR_DEV_THR, 32'h400);
    rchk("tlim", ADDR_TLIM, 32'h12C);
    rchk("unmapped", 8'h18, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    for (int i = 0; i < 8; i++) begin
      if (i == 4) host.run(1'b1);
      raise(i);
      chk("code", 32'(exp_code[i]), 32'(disp_code));
      chk("ok_out", 32'h0, 32'(fault_ok_output));
      chk("stop", 32'h1, 32'(motor_stop));
      host.pulse(1'b1);
      tick(3);
      chk("host_clear", 32'(exp_clr[i]), 32'(fault_ok_output));
      chk("reset_ind", 32'(exp_clr[i]), 32'(disp_reset_ind));
      do_reset();
      chk("por_clear", 32'h1, 32'(fault_ok_output));
    end
    raise(3);
    host.run(1'b1);
    host.pulse(1'b0);
    tick(3);
    chk("run_blocks", 32'h0, 32'(fault_ok_output));
    reverse_run_input <= 1'b1;
    host.pulse(1'b1);
    tick(3);
    chk("rev_blocks", 32'h0, 32'(fault_ok_output));
    reverse_run_input <= 1'b0;
    host.pulse(1'b1);
    host.run(1'b1);
    tick(3);
    chk("ind_kept", 32'h1, 32'(disp_reset_ind));
    panel_item_step <= 1'b1;
    tick(1);
    panel_item_step <= 1'b0;
    tick(1);
    chk("ind_step", 32'h0, 32'(disp_reset_ind));
    host.run(1'b0);
    for (int k = 0; k < 11; k++) begin
      raise(k % 2 == 0 ? 3 : 0);
      apb(1'b1, ADDR_CTRL, 32'h1);
    end
    tick(1);
    chk("sw_clear", 32'h1, 32'(fault_ok_output));
    rchk("hcnt", ADDR_HCNT, 32'hA);
    rchk("newest", ADDR_HIST0, 32'h25);
    rchk("oldest", ADDR_HLAST, 32'h10);
    apb(1'b1, ADDR_CTRL, 32'h2);
    rchk("hcnt_sw", ADDR_HCNT, 32'h0);
    raise(0);
    panel_alarm_clear <= 1'b1;
    tick(1);
    panel_alarm_clear <= 1'b0;
    panel_hist_clear <= 1'b1;
    tick(1);
    panel_hist_clear <= 1'b0;
    tick(2);
    chk("panel_clear", 32'h1, 32'(fault_ok_output));
    rchk("hcnt_panel", ADDR_HCNT, 32'h0);
    over_torque <= 1'b1;
    tick(20);
    chk("ovld_early", 32'h1, 32'(fault_ok_output));
    tick(1);
    chk("ovld_code", 32'h30, 32'(disp_code));
    rchk("stat_ovld", ADDR_STAT, 32'h0040_3001);
    over_torque <= 1'b0;
    do_reset();
    excited <= 1'b1;
    pos_dev <= 16'h0400;
    supply_pct <= 8'h78;
    shaft_speed <= 16'h1450;
    warn_cause <= 1'b1;
    tick(3);
    chk("bounds", 32'h1, 32'(fault_ok_output));
    chk("caution_on", 32'h1, 32'(caution_output));
    warn_cause <= 1'b0;
    supply_pct <= 8'h3C;
    tick(2);
    chk("caution_off", 32'h0, 32'(caution_output));
    chk("uv_bound", 32'h1, 32'(fault_ok_output));
    apb(1'b1, ADDR_TLIM, 32'hF9);
    motor_line_lost <= 1'b1;
    tick(3);
    chk("tlim_supp", 32'h1, 32'(fault_ok_output));
    motor_line_lost <= 1'b0;
    encoder_lost <= 1'b1;
    do_reset();
    chk("init_sensor", 32'h42, 32'(disp_code));
    encoder_lost <= 1'b0;
    test_done();
  end
endmodule
`default_nettype wire
